// ===== hdl/slrx_pkg.sv
// Shared constants for the serial link receive configuration and status bank.
// Assumes a single 100 MHz clock domain and byte-wide register access.
package slrx_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] SLRX_ADDR_SYNC_WORD_MODE = 12'h104;
  localparam logic [11:0] SLRX_ADDR_MF_LEN_M1      = 12'h105;
  localparam logic [11:0] SLRX_ADDR_RELEASE_DELAY  = 12'h106;
  localparam logic [11:0] SLRX_ADDR_LINK_STATUS    = 12'h107;
  localparam logic [11:0] SLRX_ADDR_LINK_CTRL      = 12'h110;
  // ----------------------------------------------------------------
  // Reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [1:0] SLRX_SWM_RESET     = 2'h0;
  localparam logic [1:0] SLRX_SWM_CRC12     = 2'h0;
  localparam logic [7:0] SLRX_MF_LEN_RESET  = 8'h1f;
  localparam logic [5:0] SLRX_RBD_RESET     = 6'h00;
  localparam int         SLRX_BIT_EB_FAULT  = 7;
  localparam int         SLRX_BIT_LINK_UP   = 6;
  localparam int         SLRX_BIT_SYNC_LVL  = 5;
  localparam int         SLRX_BIT_REALIGNED = 4;
  localparam int         SLRX_BIT_SYSREF_CONSISTENT_FLAG   = 3;
  localparam int         SLRX_BIT_PLL_LOCK  = 2;
  localparam int         SLRX_CTRL_EN       = 0;
  localparam int         SLRX_CTRL_ENC      = 1;
  localparam int         SLRX_CTRL_SUB1     = 2;
  // ----------------------------------------------------------------
  // Timing and link constants
  // ----------------------------------------------------------------
  localparam int         SLRX_OCTETS_PER_STEP = 4;
  localparam int         SLRX_MB_FACTOR       = 256;
  localparam int         SLRX_MAX_SYSREF      = 7;
  localparam logic [7:0] SLRX_E_DEFAULT       = 8'h01;
  localparam logic [7:0] SLRX_F_DEFAULT       = 8'h02;
  // Command types seen by the host
  typedef enum logic [2:0] {
    SLRX_CMD_IDLE  = 3'b001,
    SLRX_CMD_WRITE = 3'b010,
    SLRX_CMD_READ  = 3'b100
  } slrx_cmd_t;
endpackage

// ===== hdl/slrx_if.sv
// Link between the register host and the receive configuration bank.
// Assumes both ends share mclk and nrst.
interface slrx_if (
  input wire logic mclk,
  input wire logic nrst
);
  logic        wr_en;
  logic        rd_en;
  logic [11:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        rvalid;
  modport device (input wr_en, input rd_en, input addr, input wdata, output rdata, output rvalid);
  modport host (output wr_en, output rd_en, output addr, output wdata, input rdata, input rvalid);
endinterface

// ===== hdl/slrx_release.sv
// Multiframe counter and elastic buffer release opportunity generator.
// Assumes octet_tick pulses once per received octet group of four.
module slrx_release
  import slrx_pkg::*;
#(
  parameter int CW = 16
) (
  input  wire logic          mclk,
  input  wire logic          nrst,
  input  wire logic          run,
  input  wire logic          octet_tick,
  input  wire logic          realign,
  input  wire logic [CW-1:0] period_quads,
  input  wire logic [5:0]    delay_quads,
  output logic               opportunity
);
  logic [CW-1:0] cnt_reg;
  // ----------------------------------------------------------------
  // Counter in units of four octets
  // ----------------------------------------------------------------
  // Counter wraps at the multiframe length; SYSREF realign restarts it
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
    end else if (!run || realign) begin
      cnt_reg <= '0;
    end else if (octet_tick) begin
      cnt_reg <= (cnt_reg + 1'b1 >= period_quads) ? '0 : cnt_reg + 1'b1;
    end
  end
  // four octets per step
  // Opportunity sits delay_quads steps past the counter boundary
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      opportunity <= 1'b0;
    end else begin
      opportunity <= run && octet_tick && (cnt_reg == CW'(delay_quads));
    end
  end
endmodule

// ===== hdl/slrx_device.sv
// Receive configuration and status registers of the serial link end.
// Assumes the host port and all status inputs are synchronous to mclk.
// Summary of operation
// - Two-bit sync word mode, zero means CRC-12
// - Sync word mode used only in 64b/66b
// - Received command fields are discarded
// - Multiframe length minus one resets to 31
// - Software programs only legal multiframe lengths
// - 64b/66b uses 256 times E over F
// - Each delay step adds four octets
// - Software keeps delay within legal range
// - Settings change only with link disabled; writes are not blocked while enabled
// - Buffer fault sticky, write one clears
// - Bit 6 reads link up
// - Bit 5 reads live sync level
// - Realign sticky, write one clears
// - Sysref_consistent_flag flag read-only, last SYSREF matched
// - Up to seven SYSREF pulses for alignment
// - Flags undefined in subclass 0
// - Bit 2 high when all enabled PLLs lock
// - Encoding bit: zero 8b/10b, one 64b/66b
// - Subclass 1 releases at offset opportunity
module slrx_device
  import slrx_pkg::*;
#(
  parameter int NPLL = 4
) (
  input  wire logic            mclk,
  input  wire logic            nrst,
  slrx_if.device               bus,
  input  wire logic            octet_tick,
  input  wire logic            lanes_writing,
  input  wire logic            eb_overflow,
  input  wire logic            eb_underflow,
  input  wire logic            sync_request_n,
  input  wire logic            sysref_pulse,
  input  wire logic            sysref_in_phase,
  input  wire logic [NPLL-1:0] pll_enabled,
  input  wire logic [NPLL-1:0] pll_locked,
  input  wire logic            cmd_valid,
  input  wire logic [7:0]      lane_e,
  input  wire logic [7:0]      lane_f,
  output logic                 link_enable,
  output logic                 line_encoding_select,
  output logic                 crc12_check_en,
  output logic                 link_up,
  output logic                 cmd_accept
);
  import slrx_pkg::*;

  logic [1:0]  sync_word_mode_sel_reg;
  logic [7:0]  frames_per_multiframe_less_one_reg;
  logic [5:0]  release_delay_reg;
  logic        subclass1_reg;
  logic        elastic_buffer_fault_reg;
  logic        realigned_reg;
  logic        sysref_consistent_flag_reg;
  logic        pll_ok_reg;
  logic        sync_request_level_reg;
  logic [2:0]  sysref_seen_reg;
  logic [15:0] period_quads;
  logic        opportunity;
  logic        realign_evt;
  logic        wr_status;
  logic [7:0]  status_byte;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Write strobe decode, reused for every register
  function automatic logic hit(input logic [11:0] a);
    return bus.wr_en && (bus.addr == a);
  endfunction

  assign wr_status   = hit(SLRX_ADDR_LINK_STATUS);
  assign realign_evt = link_enable && sysref_pulse && !sysref_in_phase;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // changes expected while disabled
  // Writes are not blocked while enabled; doing so would hide host bugs
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync_word_mode_sel_reg             <= SLRX_SWM_RESET;
      frames_per_multiframe_less_one_reg <= SLRX_MF_LEN_RESET;
      release_delay_reg                  <= SLRX_RBD_RESET;
    end else begin
      if (hit(SLRX_ADDR_SYNC_WORD_MODE)) sync_word_mode_sel_reg <= bus.wdata[1:0];
      if (hit(SLRX_ADDR_MF_LEN_M1)) frames_per_multiframe_less_one_reg <= bus.wdata;
      if (hit(SLRX_ADDR_RELEASE_DELAY)) release_delay_reg <= bus.wdata[5:0];
    end
  end

  // Link control: enable, encoding, subclass
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      link_enable          <= 1'b0;
      line_encoding_select <= 1'b0;
      subclass1_reg        <= 1'b0;
    end else if (hit(SLRX_ADDR_LINK_CTRL)) begin
      link_enable          <= bus.wdata[SLRX_CTRL_EN];
      line_encoding_select <= bus.wdata[SLRX_CTRL_ENC];
      subclass1_reg        <= bus.wdata[SLRX_CTRL_SUB1];
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // only in 64b/66b
  // zero selects CRC-12, reserved codes check nothing
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      crc12_check_en <= 1'b0;
    end else begin
      crc12_check_en <= line_encoding_select && (sync_word_mode_sel_reg == SLRX_SWM_CRC12);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cmd_accept <= 1'b0;
    end else begin
      cmd_accept <= 1'b0 & cmd_valid;
    end
  end

  // multiframe 256*E/F in 64b/66b
  // Period held in quads of octets: K*F/4; a period of zero treated as one quad
  always_comb begin
    if (line_encoding_select) begin
      period_quads = 16'((SLRX_MB_FACTOR * int'(lane_e))
                         / SLRX_OCTETS_PER_STEP);
    end else begin
      period_quads = 16'(((int'(frames_per_multiframe_less_one_reg) + 1) * int'(lane_f))
                         / SLRX_OCTETS_PER_STEP);
    end
    if (period_quads == 16'h0000) period_quads = 16'h0001;
  end

  slrx_release #(
    .CW (16)
  ) u_release (
    .mclk         (mclk),
    .nrst         (nrst),
    .run          (link_enable),
    .octet_tick   (octet_tick),
    .realign      (realign_evt),
    .period_quads (period_quads),
    .delay_quads  (release_delay_reg),
    .opportunity  (opportunity)
  );

  // ----------------------------------------------------------------
  // Link up and buffer release
  // ----------------------------------------------------------------
  // subclass 1 release at opportunity
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      link_up <= 1'b0;
    end else if (!link_enable || !sync_request_n) begin
      link_up <= 1'b0;
    end else if (lanes_writing && (!subclass1_reg || opportunity)) begin
      link_up <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // fault sticky, W1C
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      elastic_buffer_fault_reg <= 1'b0;
    end else if (eb_overflow || eb_underflow) begin
      elastic_buffer_fault_reg <= 1'b1;
    end else if (wr_status && bus.wdata[SLRX_BIT_EB_FAULT]) begin
      elastic_buffer_fault_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      realigned_reg <= 1'b0;
    end else if (realign_evt) begin
      realigned_reg <= 1'b1;
    end else if (wr_status && bus.wdata[SLRX_BIT_REALIGNED]) begin
      realigned_reg <= 1'b0;
    end
  end

  // needs up to seven pulses
  // First pulse after enable never sets the consistent flag; an out-of-phase one still sets realigned
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sysref_seen_reg            <= 3'h0;
      sysref_consistent_flag_reg <= 1'b0;
    end else if (!link_enable) begin
      sysref_seen_reg            <= 3'h0;
      sysref_consistent_flag_reg <= 1'b0;
    end else if (sysref_pulse) begin
      if (sysref_seen_reg != 3'(SLRX_MAX_SYSREF)) sysref_seen_reg <= sysref_seen_reg + 3'h1;
      sysref_consistent_flag_reg <= sysref_in_phase && (sysref_seen_reg != 3'h0);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pll_ok_reg             <= 1'b0;
      sync_request_level_reg <= 1'b0;
    end else begin
      pll_ok_reg             <= &(pll_locked | ~pll_enabled);
      sync_request_level_reg <= sync_request_n;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // bit 6 link up
  assign status_byte = {elastic_buffer_fault_reg, link_up, sync_request_level_reg,
                        realigned_reg, sysref_consistent_flag_reg, pll_ok_reg, 2'h0};

  // One cycle read latency; unmapped addresses read zero
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bus.rdata  <= 8'h00;
      bus.rvalid <= 1'b0;
    end else begin
      bus.rvalid <= bus.rd_en;
      case (bus.addr)
        SLRX_ADDR_SYNC_WORD_MODE: bus.rdata <= {6'h00, sync_word_mode_sel_reg};
        SLRX_ADDR_MF_LEN_M1:      bus.rdata <= frames_per_multiframe_less_one_reg;
        SLRX_ADDR_RELEASE_DELAY:  bus.rdata <= {2'h0, release_delay_reg};
        SLRX_ADDR_LINK_STATUS:    bus.rdata <= status_byte;
        SLRX_ADDR_LINK_CTRL:      bus.rdata <= {5'h00, subclass1_reg, line_encoding_select,
                                                link_enable};
        default:                  bus.rdata <= 8'h00;
      endcase
    end
  end
endmodule

// ===== hdl/slrx_host.sv
// Host end: issues single register writes and reads to the bank.
// Assumes the user holds a request until req_ready and rules are kept.
module slrx_host
  import slrx_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  slrx_if.host             bus,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [11:0] req_addr,
  input  wire logic [7:0]  req_wdata,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic [7:0]       rsp_rdata
);
  import slrx_pkg::*;
  slrx_cmd_t state_reg;
  // ----------------------------------------------------------------
  // Request sequencer
  // ----------------------------------------------------------------
  // user supplies K minus one
  // legality and ordering left to the user
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= SLRX_CMD_IDLE;
      bus.wr_en <= 1'b0;
      bus.rd_en <= 1'b0;
      bus.addr  <= 12'h000;
      bus.wdata <= 8'h00;
      req_ready <= 1'b1;
    end else begin
      bus.wr_en <= 1'b0;
      bus.rd_en <= 1'b0;
      case (state_reg)
        SLRX_CMD_IDLE: begin
          if (req_valid) begin
            bus.addr  <= req_addr;
            bus.wdata <= req_wdata;
            bus.wr_en <= req_write;
            bus.rd_en <= !req_write;
            req_ready <= 1'b0;
            state_reg <= req_write ? SLRX_CMD_WRITE : SLRX_CMD_READ;
          end
        end
        SLRX_CMD_WRITE: begin
          req_ready <= 1'b1;
          state_reg <= SLRX_CMD_IDLE;
        end
        SLRX_CMD_READ: begin
          if (bus.rvalid) begin
            req_ready <= 1'b1;
            state_reg <= SLRX_CMD_IDLE;
          end
        end
        default: state_reg <= SLRX_CMD_IDLE;
      endcase
    end
  end
  // Read response capture
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
    end else begin
      rsp_valid <= (state_reg == SLRX_CMD_READ) && bus.rvalid;
      if ((state_reg == SLRX_CMD_READ) && bus.rvalid) rsp_rdata <= bus.rdata;
    end
  end
endmodule

// ===== sim/slrx_chk.sv
// Concurrent checks on the register link between host and device ends.
// Assumes the bench ties it to the interface signals of the mclk domain.
module slrx_chk
  import slrx_pkg::*;
(
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [11:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic [7:0]  rdata,
  input wire logic        rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] ra_reg;
  logic [7:0]  mfl_reg;
  logic [5:0]  dly_reg;
  logic [1:0]  swm_reg;
  logic [2:0]  ctl_reg;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ------------------------------------------------------------
  // Helper state
  // ------------------------------------------------------------
  // Address of the read in flight, so no readback property needs lookback
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) ra_reg <= 12'h000;
    else if (rd_en) ra_reg <= addr;
  end
  // Mirror of writable fields; reserved bits are not judged
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mfl_reg <= SLRX_MF_LEN_RESET;
      dly_reg <= SLRX_RBD_RESET;
      swm_reg <= SLRX_SWM_RESET;
      ctl_reg <= 3'h0;
    end else if (wr_en) begin
      if (addr == SLRX_ADDR_SYNC_WORD_MODE) swm_reg <= wdata[1:0];
      if (addr == SLRX_ADDR_MF_LEN_M1) mfl_reg <= wdata;
      if (addr == SLRX_ADDR_RELEASE_DELAY) dly_reg <= wdata[5:0];
      if (addr == SLRX_ADDR_LINK_CTRL) ctl_reg <= wdata[2:0];
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_read_answer; rd_en |=> rvalid; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_no_stray; rvalid |-> $past(rd_en); endproperty
  a_no_stray: assert property (p_no_stray) else $error("answer without read");
  property p_swm_rb; rvalid && ra_reg == SLRX_ADDR_SYNC_WORD_MODE |-> rdata[1:0] == swm_reg;
  endproperty
  a_swm_rb: assert property (p_swm_rb) else $error("sync word mode readback");
  property p_mfl_rb; rvalid && ra_reg == SLRX_ADDR_MF_LEN_M1 |-> rdata == mfl_reg; endproperty
  a_mfl_rb: assert property (p_mfl_rb) else $error("multiframe length readback");
  property p_dly_rb; rvalid && ra_reg == SLRX_ADDR_RELEASE_DELAY |-> rdata[5:0] == dly_reg;
  endproperty
  a_dly_rb: assert property (p_dly_rb) else $error("release delay readback");
  property p_ctl_rb; rvalid && ra_reg == SLRX_ADDR_LINK_CTRL |-> rdata[2:0] == ctl_reg;
  endproperty
  a_ctl_rb: assert property (p_ctl_rb) else $error("control readback");
  property p_st_low; rvalid && ra_reg == SLRX_ADDR_LINK_STATUS |-> rdata[1:0] == 2'h0;
  endproperty
  a_st_low: assert property (p_st_low) else $error("status low bits not zero");
  property p_unmapped; rvalid && !(ra_reg inside {[12'h104:12'h107], 12'h110})
    |-> rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

// ===== sim/tb_serial_link_rx_cfg_status.sv
// Self-checking bench: host end and device end joined through the interface.
// Assumes package, interface and both design ends are compiled before it.
module tb_serial_link_rx_cfg_status import slrx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] SWM = SLRX_ADDR_SYNC_WORD_MODE;
  localparam logic [11:0] MFL = SLRX_ADDR_MF_LEN_M1;
  localparam logic [11:0] DLY = SLRX_ADDR_RELEASE_DELAY;
  localparam logic [11:0] ST  = SLRX_ADDR_LINK_STATUS;
  localparam logic [11:0] CT  = SLRX_ADDR_LINK_CTRL;
  localparam logic [11:0] WADR [4] = '{SWM, MFL, DLY, 12'h1ff};
  logic        mclk, nrst, octet_tick, lanes_writing, eb_overflow, eb_underflow;
  logic        sync_request_n, sysref_pulse, sysref_in_phase, cmd_valid;
  logic [3:0]  pll_enabled, pll_locked;
  logic [7:0]  lane_e, lane_f, v, req_wdata, rsp_rdata;
  logic        link_enable, line_encoding_select, crc12_check_en, link_up, cmd_accept;
  logic        req_valid, req_write, req_ready, rsp_valid;
  logic [11:0] req_addr;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  int          miscompares = 0;
  int          checked = 0;
  int          nt;
  slrx_if link_if (.mclk(mclk), .nrst(nrst));
  slrx_device #(.NPLL(4)) slrx_device_inst (.mclk(mclk), .nrst(nrst), .bus(link_if.device),
    .octet_tick(octet_tick), .lanes_writing(lanes_writing), .eb_overflow(eb_overflow),
    .eb_underflow(eb_underflow), .sync_request_n(sync_request_n), .sysref_pulse(sysref_pulse),
    .sysref_in_phase(sysref_in_phase), .pll_enabled(pll_enabled), .pll_locked(pll_locked),
    .cmd_valid(cmd_valid), .lane_e(lane_e), .lane_f(lane_f), .link_enable(link_enable),
    .line_encoding_select(line_encoding_select), .crc12_check_en(crc12_check_en),
    .link_up(link_up), .cmd_accept(cmd_accept));
  slrx_host slrx_host_inst (.mclk(mclk), .nrst(nrst), .bus(link_if.host),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata));
  slrx_chk slrx_chk_inst (.mclk(mclk), .nrst(nrst), .wr_en(link_if.wr_en),
    .rd_en(link_if.rd_en), .addr(link_if.addr), .wdata(link_if.wdata),
    .rdata(link_if.rdata), .rvalid(link_if.rvalid));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One request; a read notes {mask, expected} and waits for its answer
  task automatic req(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     input logic [7:0] m);
    for (int n = 0; req_ready !== 1'b1; n++) begin
      if (n > 50) begin
        miscompares++;
        give_verdict();
      end
      step(1);
    end
    req_valid = 1'b1;
    req_write = wr;
    req_addr  = a;
    req_wdata = d;
    if (!wr) exp_q.push_back({m, d});
    step(1);
    req_valid = 1'b0;
    for (int n = 0; n < 20 && exp_q.size() != 0; n++) step(1);
    if (exp_q.size() != 0) begin
      miscompares++;
      give_verdict();
    end
  endtask
  task automatic pulse_sysref(input logic ph);
    sysref_in_phase = ph;
    sysref_pulse    = 1'b1;
    step(1);
    sysref_pulse = 1'b0;
    step(3);
  endtask
  // ------------------------------------------------------------
  // Clock and response watcher
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Takes the oldest note whenever the host presents read data
  always @(posedge mclk) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) check(8'hxx, 8'h00);
      else begin
        e = exp_q.pop_front();
        check(rsp_rdata & e[15:8], e[7:0]);
      end
    end
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {nrst, req_valid, req_write, req_addr, req_wdata, octet_tick} = '0;
    {lanes_writing, eb_overflow, eb_underflow, sysref_pulse, sysref_in_phase} = '0;
    {sync_request_n, cmd_valid, pll_enabled, pll_locked, lane_f} = {2'b10, 8'hff, 8'h02};
    lane_e = SLRX_E_DEFAULT;
    void'($urandom(32'hf6bf));
    step(12);
    nrst = 1'b1;
    req(0, SWM, 8'h00, 8'hff);
    req(0, MFL, 8'h1f, 8'hff);
    req(0, DLY, 8'h00, 8'hff);
    req(0, ST, 8'h24, 8'hff);
    req(0, 12'h1ff, 8'h00, 8'hff);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      for (int k = 0; k < 4; k++) req(1, WADR[k], v, 8'h00);
      req(0, SWM, v & 8'h03, 8'h03);
      req(0, MFL, v, 8'hff);
      req(0, DLY, v & 8'h3f, 8'h3f);
      req(0, 12'h1ff, 8'h00, 8'hff);
    end
    $display("Test register readback done");
    for (int k = 0; k < 2; k++) begin
      {eb_underflow, eb_overflow} = k ? 2'b10 : 2'b01;
      step(1);
      {eb_underflow, eb_overflow} = 2'b00;
      req(0, ST, 8'h80, 8'h80);
      req(1, ST, 8'h80, 8'h00);
      req(0, ST, 8'h00, 8'h80);
    end
    // The write lands one edge after the task returns; the fault hits that same edge
    req(1, ST, 8'h80, 8'h00);
    eb_overflow = 1'b1;
    step(1);
    eb_overflow = 1'b0;
    req(0, ST, 8'h80, 8'h80);
    req(1, ST, 8'h80, 8'h00);
    $display("Test buffer fault done");
    req(1, CT, 8'h05, 8'h00);
    // Enable takes effect one edge after the write is issued
    step(1);
    pulse_sysref(1'b0);
    req(0, ST, 8'h10, 8'h18);
    for (int i = 0; i < SLRX_MAX_SYSREF; i++) pulse_sysref(1'b1);
    req(0, ST, 8'h18, 8'h18);
    req(1, ST, 8'h18, 8'h00);
    req(0, ST, 8'h08, 8'h18);
    req(1, CT, 8'h00, 8'h00);
    req(0, ST, 8'h00, 8'h08);
    $display("Test sysref flags done");
    for (int i = 0; i < 6; i++) begin
      pll_enabled = 4'($urandom);
      pll_locked  = 4'($urandom);
      step(2);
      req(0, ST, ((pll_enabled & pll_locked) == pll_enabled) ? 8'h04 : 8'h00, 8'h04);
      sync_request_n = i[0];
      step(2);
      req(0, ST, {2'b00, sync_request_n, 5'h00}, 8'h20);
    end
    $display("Test live status done");
    for (int k = 0; k < 4; k++) begin
      req(1, SWM, {7'h00, k[0]}, 8'h00);
      req(1, CT, {6'h00, k[1], 1'b0}, 8'h00);
      step(3);
      check({7'h00, crc12_check_en}, {7'h00, k == 2});
      check({7'h00, line_encoding_select}, {7'h00, k[1]});
    end
    $display("Test encoding select done");
    sync_request_n = 1'b1;
    lanes_writing  = 1'b1;
    cmd_valid      = 1'b1;
    req(1, CT, 8'h01, 8'h00);
    step(4);
    check({link_enable, link_up, cmd_accept}, 8'h06);
    req(0, ST, 8'h40, 8'h40);
    sync_request_n = 1'b0;
    step(3);
    check({7'h00, link_up}, 8'h00);
    sync_request_n = 1'b1;
    req(1, CT, 8'h00, 8'h00);
    req(1, MFL, 8'h03, 8'h00);
    req(1, DLY, 8'h01, 8'h00);
    req(1, CT, 8'h05, 8'h00);
    step(20);
    check({7'h00, link_up}, 8'h00);
    for (nt = 0; nt < 40 && link_up !== 1'b1; nt++) begin
      octet_tick = ~octet_tick;
      step(1);
    end
    check({7'h00, link_up}, 8'h01);
    // One quad of delay: release on the second tick, two toggles per tick
    check(8'(nt), 8'h04);
    $display("Test link release done");
    req(1, CT, 8'h00, 8'h00);
    req(1, DLY, 8'h3f, 8'h00);
    req(1, CT, 8'h07, 8'h00);
    step(1);
    octet_tick = 1'b0;
    for (nt = 0; nt < 200 && link_up !== 1'b1; nt++) begin
      octet_tick = ~octet_tick;
      step(1);
    end
    // Delay 63 is only reachable if the 64-quad period replaces the short K
    check(8'(nt), 8'h80);
    $display("Test long multiblock done");
    give_verdict();
  end
endmodule
